// >>> core/bbe_consts.svh
// Offsets, field positions and reset values of the branch and bit unit
`ifndef BBE_CONSTS_SVH
`define BBE_CONSTS_SVH

// APB register byte offsets
`define BBE_OFS_FLAGS   8'h00
`define BBE_OFS_PC      8'h04
`define BBE_OFS_STATE   8'h08

// Status flag positions
`define BBE_FLAG_C      0
`define BBE_FLAG_Z      1
`define BBE_FLAG_N      2
`define BBE_FLAG_V      3
`define BBE_FLAG_S      4
`define BBE_FLAG_H      5
`define BBE_FLAG_T      6
`define BBE_FLAG_I      7

// Unit state register fields
`define BBE_STATE_BUSY  0
`define BBE_STATE_TAKEN 1

// Reset values
`define BBE_RST_FLAGS   8'h00
`define BBE_RST_PC      16'h0000

`endif

// >>> core/bbe_pkg.sv
// Types of the branch and bit unit
package bbe_pkg;

  // Operation codes presented on the instruction port
  typedef enum logic [4:0] {
    NOP_OP                     = 5'h00,
    BRANCH_ON_EQUAL            = 5'h01,
    BRANCH_ON_UNEQUAL          = 5'h02,
    BRANCH_CARRY_ONE           = 5'h03,
    BRANCH_CARRY_ZERO          = 5'h04,
    BRANCH_SAME_OR_HIGHER      = 5'h05,
    BRANCH_LOWER               = 5'h06,
    BRANCH_NEGATIVE            = 5'h07,
    BRANCH_POSITIVE            = 5'h08,
    BRANCH_SIGNED_GE           = 5'h09,
    BRANCH_SIGNED_LESS         = 5'h0a,
    BRANCH_HALF_CARRY_ONE      = 5'h0b,
    BRANCH_HALF_CARRY_ZERO     = 5'h0c,
    BRANCH_TRANSFER_ONE        = 5'h0d,
    BRANCH_TRANSFER_ZERO       = 5'h0e,
    BRANCH_OVERFLOW_ONE        = 5'h0f,
    BRANCH_OVERFLOW_ZERO       = 5'h10,
    BRANCH_IRQ_ENABLED         = 5'h11,
    BRANCH_IRQ_DISABLED        = 5'h12,
    SET_IO_BIT                 = 5'h13,
    CLEAR_IO_BIT               = 5'h14,
    SHIFT_LEFT_LOGICAL         = 5'h15,
    SHIFT_RIGHT_LOGICAL        = 5'h16,
    ROTATE_LEFT_CARRY          = 5'h17,
    ROTATE_RIGHT_CARRY         = 5'h18,
    SHIFT_RIGHT_ARITH          = 5'h19,
    SWAP_NIBBLES               = 5'h1a,
    STORE_BIT_TO_TRANSFER_FLAG = 5'h1b,
    LOAD_BIT_FROM_TRANSFER_FLAG= 5'h1c,
    STATUS_FLAG_SET_OP         = 5'h1d,
    STATUS_FLAG_CLEAR_OP       = 5'h1e
  } bbe_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_BR_WAIT = 2'b01,
    ST_IO_WR   = 2'b10
  } bbe_state_t;

endpackage : bbe_pkg

// >>> core/bbe_branch_bit_exec.sv
// Branch, bit, shift and flag execution unit with APB status access
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "bbe_consts.svh"

// How it works
// - Taken branch loads pc+k+1, two cycles
// - Equal tests zero one, unequal zero zero
// - Carry branches: lower/set on one, else zero
// - Negative on N one, positive on zero
// - Signed ge/less test N xor V
// - Half-carry branches test H one or zero
// - Transfer branches test T one or zero
// - Overflow branches test V one or zero
// - Interrupt branches test I; branches keep flags
// - Set/clear I/O bit, two cycles, flags kept
// - Shift left, zero into bit 0, flags
// - Shift right, zero into bit 7, flags
// - Rotates move carry in and out
// - Arithmetic right shift keeps sign bit
// - Swap exchanges nibbles, flags kept
// - Bit store to T, bit load from T
module bbe_branch_bit_exec (
  input  wire logic           mclk,
  input  wire logic           sys_rst,
  input  wire logic           ce,
  input  wire logic           instValid,
  input  wire logic [4:0]     instOp,
  input  wire logic [6:0]     instOffset,
  input  wire logic [2:0]     instBit,
  input  wire logic [4:0]     instReg,
  input  wire logic [7:0]     instRegData,
  input  wire logic [4:0]     instIoAddr,
  input  wire logic [7:0]     ioRdData,
  output logic                ready_reg,
  output logic [15:0]         pc_reg,
  output logic [7:0]          flags_reg,
  output logic                regWrEn_reg,
  output logic [4:0]          regWrAddr_reg,
  output logic [7:0]          regWrData_reg,
  output logic [4:0]          ioAddr_reg,
  output logic                ioWrEn_reg,
  output logic [7:0]          ioWrData_reg,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic                pready_reg,
  output logic [31:0]         prdata_reg,
  output logic                pslverr_reg
);

  bbe_pkg::bbe_op_t    op;
  bbe_pkg::bbe_state_t state_reg;
  bbe_pkg::bbe_state_t state_next;
  logic                accept;
  logic                isBranch;
  logic                brCond;
  logic                lastTaken_reg;
  logic [15:0]         pcInc;
  logic [15:0]         brTarget;
  logic [2:0]          ioBit_reg;
  logic                ioSet_reg;
  logic                isShift;
  logic [7:0]          shRes;
  logic                shCarry;
  logic                apbWr;
  logic                apbMapped;
  logic                quiet;

  assign op     = bbe_pkg::bbe_op_t'(instOp);
  assign accept = ce && instValid && ready_reg
                  && (state_reg == bbe_pkg::ST_IDLE);
  assign pcInc  = pc_reg + 16'h0001;
  // Sign-extended offset plus one
  assign brTarget = pc_reg + {{9{instOffset[6]}}, instOffset} + 16'h0001;

  // Branch condition select
  always_comb begin
    isBranch = 1'b1;
    brCond   = 1'b0;
    unique case (op)
      bbe_pkg::BRANCH_ON_EQUAL:        brCond = flags_reg[`BBE_FLAG_Z];
      bbe_pkg::BRANCH_ON_UNEQUAL:      brCond = !flags_reg[`BBE_FLAG_Z];
      bbe_pkg::BRANCH_CARRY_ONE,
      bbe_pkg::BRANCH_LOWER:           brCond = flags_reg[`BBE_FLAG_C];
      bbe_pkg::BRANCH_CARRY_ZERO,
      bbe_pkg::BRANCH_SAME_OR_HIGHER:  brCond = !flags_reg[`BBE_FLAG_C];
      bbe_pkg::BRANCH_NEGATIVE:        brCond = flags_reg[`BBE_FLAG_N];
      bbe_pkg::BRANCH_POSITIVE:        brCond = !flags_reg[`BBE_FLAG_N];
      bbe_pkg::BRANCH_SIGNED_GE:       brCond = !(flags_reg[`BBE_FLAG_N]
                                          ^ flags_reg[`BBE_FLAG_V]);
      bbe_pkg::BRANCH_SIGNED_LESS:     brCond = flags_reg[`BBE_FLAG_N]
                                          ^ flags_reg[`BBE_FLAG_V];
      bbe_pkg::BRANCH_HALF_CARRY_ONE:  brCond = flags_reg[`BBE_FLAG_H];
      bbe_pkg::BRANCH_HALF_CARRY_ZERO: brCond = !flags_reg[`BBE_FLAG_H];
      bbe_pkg::BRANCH_TRANSFER_ONE:    brCond = flags_reg[`BBE_FLAG_T];
      bbe_pkg::BRANCH_TRANSFER_ZERO:   brCond = !flags_reg[`BBE_FLAG_T];
      bbe_pkg::BRANCH_OVERFLOW_ONE:    brCond = flags_reg[`BBE_FLAG_V];
      bbe_pkg::BRANCH_OVERFLOW_ZERO:   brCond = !flags_reg[`BBE_FLAG_V];
      bbe_pkg::BRANCH_IRQ_ENABLED:     brCond = flags_reg[`BBE_FLAG_I];
      bbe_pkg::BRANCH_IRQ_DISABLED:    brCond = !flags_reg[`BBE_FLAG_I];
      default:                         isBranch = 1'b0;
    endcase
  end

  // Shift and rotate results with outgoing carry
  always_comb begin
    isShift = 1'b1;
    shRes   = instRegData;
    shCarry = flags_reg[`BBE_FLAG_C];
    unique case (op)
      bbe_pkg::SHIFT_LEFT_LOGICAL: begin
        shRes   = {instRegData[6:0], 1'b0};
        shCarry = instRegData[7];
      end
      bbe_pkg::SHIFT_RIGHT_LOGICAL: begin
        shRes   = {1'b0, instRegData[7:1]};
        shCarry = instRegData[0];
      end
      bbe_pkg::ROTATE_LEFT_CARRY: begin
        shRes   = {instRegData[6:0], flags_reg[`BBE_FLAG_C]};
        shCarry = instRegData[7];
      end
      bbe_pkg::ROTATE_RIGHT_CARRY: begin
        shRes   = {flags_reg[`BBE_FLAG_C], instRegData[7:1]};
        shCarry = instRegData[0];
      end
      bbe_pkg::SHIFT_RIGHT_ARITH: begin
        shRes   = {instRegData[7], instRegData[7:1]};
        shCarry = instRegData[0];
      end
      default: isShift = 1'b0;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bbe_pkg::ST_IDLE: begin
        if (accept && isBranch && brCond) begin
          state_next = bbe_pkg::ST_BR_WAIT;
        end else if (accept && (op == bbe_pkg::SET_IO_BIT
                                || op == bbe_pkg::CLEAR_IO_BIT)) begin
          state_next = bbe_pkg::ST_IO_WR;
        end
      end
      bbe_pkg::ST_BR_WAIT: state_next = bbe_pkg::ST_IDLE;
      bbe_pkg::ST_IO_WR:   state_next = bbe_pkg::ST_IDLE;
      default:             state_next = bbe_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state and ready
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg     <= bbe_pkg::ST_IDLE;
      ready_reg     <= 1'b0;
      lastTaken_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      ready_reg <= (state_next == bbe_pkg::ST_IDLE);
      if (accept && isBranch) begin
        lastTaken_reg <= brCond;
      end
    end
  end

  // APB decode
  assign apbWr     = psel && penable && pready_reg && pwrite;
  assign apbMapped = (paddr == `BBE_OFS_FLAGS) || (paddr == `BBE_OFS_PC)
                     || (paddr == `BBE_OFS_STATE);

  // Program counter; software write wins over execution
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pc_reg <= `BBE_RST_PC;
    end else if (ce) begin
      if (apbWr && paddr == `BBE_OFS_PC) begin
        pc_reg <= pwdata[15:0];
      end else if (accept && isBranch && brCond) begin
        pc_reg <= brTarget;
      end else if (accept) begin
        pc_reg <= pcInc;
      end
    end
  end

  // Status flags; branches, I/O bit ops and swap leave them alone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_reg <= `BBE_RST_FLAGS;
    end else if (ce) begin
      if (apbWr && paddr == `BBE_OFS_FLAGS) begin
        flags_reg <= pwdata[7:0];
      end else if (accept && isShift) begin
        flags_reg[`BBE_FLAG_C] <= shCarry;
        flags_reg[`BBE_FLAG_Z] <= (shRes == 8'h00);
        flags_reg[`BBE_FLAG_N] <= shRes[7];
        flags_reg[`BBE_FLAG_V] <= shRes[7] ^ shCarry;
      end else if (accept && op == bbe_pkg::STORE_BIT_TO_TRANSFER_FLAG) begin
        flags_reg[`BBE_FLAG_T] <= instRegData[instBit];
      end else if (accept && op == bbe_pkg::STATUS_FLAG_SET_OP) begin
        flags_reg[instBit] <= 1'b1;
      end else if (accept && op == bbe_pkg::STATUS_FLAG_CLEAR_OP) begin
        flags_reg[instBit] <= 1'b0;
      end
    end
  end

  // Register file write-back, one-cycle pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regWrEn_reg   <= 1'b0;
      regWrAddr_reg <= 5'h00;
      regWrData_reg <= 8'h00;
    end else if (ce) begin
      regWrEn_reg   <= 1'b0;
      regWrAddr_reg <= instReg;
      if (accept && isShift) begin
        regWrEn_reg   <= 1'b1;
        regWrData_reg <= shRes;
      end else if (accept && op == bbe_pkg::SWAP_NIBBLES) begin
        regWrEn_reg   <= 1'b1;
        regWrData_reg <= {instRegData[3:0], instRegData[7:4]};
      end else if (accept && op == bbe_pkg::LOAD_BIT_FROM_TRANSFER_FLAG) begin
        regWrEn_reg   <= 1'b1;
        regWrData_reg <= instRegData;
        regWrData_reg[instBit] <= flags_reg[`BBE_FLAG_T];
      end
    end
  end

  // I/O read-modify-write over two cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ioAddr_reg   <= 5'h00;
      ioBit_reg    <= 3'h0;
      ioSet_reg    <= 1'b0;
      ioWrEn_reg   <= 1'b0;
      ioWrData_reg <= 8'h00;
    end else if (ce) begin
      ioWrEn_reg <= 1'b0;
      if (state_next == bbe_pkg::ST_IO_WR) begin
        ioAddr_reg <= instIoAddr;
        ioBit_reg  <= instBit;
        ioSet_reg  <= (op == bbe_pkg::SET_IO_BIT);
      end
      if (state_reg == bbe_pkg::ST_IO_WR) begin
        ioWrEn_reg   <= 1'b1;
        ioWrData_reg <= ioRdData;
        ioWrData_reg[ioBit_reg] <= ioSet_reg;
      end
    end
  end

  // APB slave, one wait-free access phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !apbMapped;
      prdata_reg  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == `BBE_OFS_FLAGS) begin
          prdata_reg[7:0] <= flags_reg;
        end else if (paddr == `BBE_OFS_PC) begin
          prdata_reg[15:0] <= pc_reg;
        end else if (paddr == `BBE_OFS_STATE) begin
          prdata_reg[`BBE_STATE_BUSY]  <= (state_reg != bbe_pkg::ST_IDLE);
          prdata_reg[`BBE_STATE_TAKEN] <= lastTaken_reg;
        end
      end
    end
  end

  // Assertion helper: accepted instruction with no software override
  assign quiet = accept && !apbWr;

  br_taken_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && isBranch && brCond |=> pc_reg == $past(brTarget) && !ready_reg)
    else $error("taken branch target or stall wrong");
  br_skip_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && isBranch && !brCond |=> pc_reg == $past(pcInc) && ready_reg)
    else $error("untaken branch did not advance");
  br_equal_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_ON_EQUAL |=>
    (pc_reg == $past(brTarget)) == $past(flags_reg[`BBE_FLAG_Z])
    || $past(brTarget) == $past(pcInc))
    else $error("equal branch ignores zero flag");
  br_lower_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_LOWER && !flags_reg[`BBE_FLAG_C]
    |=> pc_reg == $past(pcInc))
    else $error("lower branch taken with carry clear");
  br_plus_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_POSITIVE && !flags_reg[`BBE_FLAG_N]
    |=> pc_reg == $past(brTarget))
    else $error("plus branch not taken");
  br_signed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_SIGNED_LESS
    && (flags_reg[`BBE_FLAG_N] ^ flags_reg[`BBE_FLAG_V])
    |=> pc_reg == $past(brTarget))
    else $error("signed less branch not taken");
  br_half_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_HALF_CARRY_ZERO
    && flags_reg[`BBE_FLAG_H] |=> pc_reg == $past(pcInc))
    else $error("half carry clear branch taken wrongly");
  br_transfer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_TRANSFER_ONE && flags_reg[`BBE_FLAG_T]
    |=> pc_reg == $past(brTarget))
    else $error("transfer set branch not taken");
  br_overflow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::BRANCH_OVERFLOW_ZERO && flags_reg[`BBE_FLAG_V]
    |=> pc_reg == $past(pcInc))
    else $error("overflow clear branch taken wrongly");
  br_flags_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && isBranch |=> $stable(flags_reg))
    else $error("branch changed status flags");
  io_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::SET_IO_BIT && ce ##1 ce |=>
    ioWrEn_reg && ioWrData_reg[ioBit_reg] && $stable(flags_reg))
    else $error("I/O bit set not written in two cycles");
  shift_left_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::SHIFT_LEFT_LOGICAL |=> regWrEn_reg
    && regWrData_reg == {$past(instRegData[6:0]), 1'b0}
    && flags_reg[`BBE_FLAG_C] == $past(instRegData[7]))
    else $error("left shift result or carry wrong");
  shift_right_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::SHIFT_RIGHT_LOGICAL |=> !regWrData_reg[7]
    && flags_reg[`BBE_FLAG_Z] == (regWrData_reg == 8'h00))
    else $error("right shift bit 7 or zero flag wrong");
  rotate_left_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::ROTATE_LEFT_CARRY |=>
    regWrData_reg[0] == $past(flags_reg[`BBE_FLAG_C])
    && flags_reg[`BBE_FLAG_C] == $past(instRegData[7]))
    else $error("rotate left carry path wrong");
  arith_sign_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::SHIFT_RIGHT_ARITH |=>
    regWrData_reg == {$past(instRegData[7]), $past(instRegData[7:1])})
    else $error("arithmetic shift lost sign");
  swap_nibble_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::SWAP_NIBBLES |=> $stable(flags_reg)
    && regWrData_reg == {$past(instRegData[3:0]), $past(instRegData[7:4])})
    else $error("swap result or flags wrong");
  bit_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::STORE_BIT_TO_TRANSFER_FLAG |=>
    flags_reg[`BBE_FLAG_T] == $past(instRegData[instBit]))
    else $error("bit store did not reach transfer flag");
  flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::STATUS_FLAG_SET_OP |=>
    flags_reg[$past(instBit)] && ready_reg)
    else $error("flag set did not force bit");
  flag_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    quiet && op == bbe_pkg::STATUS_FLAG_CLEAR_OP |=>
    !flags_reg[$past(instBit)] && ready_reg)
    else $error("flag clear did not clear bit");

endmodule : bbe_branch_bit_exec

// >>> testbench/bbe_branch_bit_exec_tb_top.sv
// Self-checking bench for the branch, bit and shift execution unit
`timescale 1ns/1ps
`include "bbe_consts.svh"
module bbe_branch_bit_exec_tb_top;
  logic        mclk, sys_rst, ce, instValid;
  logic [4:0]  instOp, instReg, instIoAddr;
  logic [6:0]  instOffset;
  logic [2:0]  instBit;
  logic [7:0]  instRegData, ioRdData;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        ready_reg, regWrEn_reg, ioWrEn_reg, pready_reg, pslverr_reg;
  logic [15:0] pc_reg;
  logic [7:0]  flags_reg, regWrData_reg, ioWrData_reg;
  logic [4:0]  regWrAddr_reg, ioAddr_reg;
  logic [31:0] prdata_reg, rdata;
  logic        rerr;
  logic [7:0]  ioMem [32];
  int          errCount, totalChecks;

  bbe_branch_bit_exec DUT (
    .mclk, .sys_rst, .ce, .instValid, .instOp, .instOffset, .instBit,
    .instReg, .instRegData, .instIoAddr, .ioRdData, .ready_reg, .pc_reg,
    .flags_reg, .regWrEn_reg, .regWrAddr_reg, .regWrData_reg, .ioAddr_reg,
    .ioWrEn_reg, .ioWrData_reg, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready_reg, .prdata_reg, .pslverr_reg
  );

  // I/O register space seen by the read-modify-write path
  assign ioRdData = ioMem[ioAddr_reg];
  always @(posedge mclk) begin
    if (ioWrEn_reg) ioMem[ioAddr_reg] <= ioWrData_reg;
  end

  // Core clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic finishTest();
    if (errCount == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest

  // A wait ran out of time
  task automatic hang();
    errCount++;
    finishTest();
  endtask : hang

  // One APB transfer; read data and error land in rdata and rerr
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready_reg !== 1'b1 && n < 20);
    if (pready_reg !== 1'b1) hang();
    rdata = prdata_reg;
    rerr = pslverr_reg;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Program flags and program counter through software access
  task automatic prep(input logic [7:0] f, input logic [15:0] p);
    apb(1'b1, `BBE_OFS_FLAGS, {24'h00_0000, f});
    apb(1'b1, `BBE_OFS_PC, {16'h0000, p});
  endtask : prep

  // Offer one instruction; returns 1 ns after the edge that took it
  task automatic exec(input logic [4:0] op, input logic [6:0] off,
                      input logic [2:0] b, input logic [7:0] d,
                      input logic [4:0] a);
    int n;
    @(posedge mclk);
    instValid <= 1'b1;
    instOp <= op;
    instOffset <= off;
    instBit <= b;
    instRegData <= d;
    instReg <= a;
    instIoAddr <= a;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ready_reg !== 1'b1 && n < 20);
    if (ready_reg !== 1'b1) hang();
    instValid <= 1'b0;
    #1;
  endtask : exec

  // Bounded wait for the unit to go idle
  task automatic waitReady();
    for (int n = 0; n < 10 && ready_reg !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (ready_reg !== 1'b1) hang();
  endtask : waitReady

  // Branch condition per code; odd codes want the flag set, bar two pairs
  function automatic logic brTaken(input logic [4:0] op, input logic [7:0] f);
    logic s;
    case (op)
      5'h01, 5'h02: s = f[`BBE_FLAG_Z];
      5'h03, 5'h04, 5'h05, 5'h06: s = f[`BBE_FLAG_C];
      5'h07, 5'h08: s = f[`BBE_FLAG_N];
      5'h09, 5'h0a: s = f[`BBE_FLAG_N] ^ f[`BBE_FLAG_V];
      5'h0b, 5'h0c: s = f[`BBE_FLAG_H];
      5'h0d, 5'h0e: s = f[`BBE_FLAG_T];
      5'h0f, 5'h10: s = f[`BBE_FLAG_V];
      default: s = f[`BBE_FLAG_I];
    endcase
    return s == (op[0] ^ (op inside {5'h05, 5'h06, 5'h09, 5'h0a}));
  endfunction : brTaken

  // Expected {flags, result} of a shift, rotate or swap
  function automatic logic [15:0] shiftExp(input logic [4:0] op,
                                           input logic [7:0] d,
                                           input logic [7:0] f);
    logic [7:0] r;
    logic       co;
    co = d[0];
    r = {d[7], d[7:1]};
    case (op)
      5'h15: r = {d[6:0], 1'b0};
      5'h16: r = {1'b0, d[7:1]};
      5'h17: r = {d[6:0], f[`BBE_FLAG_C]};
      5'h18: r = {f[`BBE_FLAG_C], d[7:1]};
      5'h1a: return {f, d[3:0], d[7:4]};
      default: r = r;
    endcase
    if (op == 5'h15 || op == 5'h17) co = d[7];
    f[`BBE_FLAG_C] = co;
    f[`BBE_FLAG_Z] = (r == 8'h00);
    f[`BBE_FLAG_N] = r[7];
    f[`BBE_FLAG_V] = r[7] ^ co;
    return {f, r};
  endfunction : shiftExp

  // Main sequence
  initial begin
    logic [7:0]  pat [4];
    logic [7:0]  dat [5];
    logic [7:0]  f;
    logic [7:0]  d;
    logic [15:0] ex;
    logic [6:0]  off;
    logic [4:0]  a;
    logic        tk;
    pat = '{8'h00, 8'hff, 8'h55, 8'haa};
    dat = '{8'h81, 8'h40, 8'h00, 8'hff, 8'h01};
    {sys_rst, ce, instValid, psel, penable, pwrite} = 6'b110000;
    {instOp, instReg, instIoAddr, instOffset, instBit} = '0;
    {instRegData, paddr, pwdata} = '0;
    errCount = 0;
    totalChecks = 0;
    for (int i = 0; i < 32; i++) ioMem[i] = 8'h00;
    repeat (16) @(posedge mclk);
    #1;
    check("pc rst", 32'(pc_reg), 32'h0000_0000);
    check("flags rst", 32'(flags_reg), 32'h0000_0000);
    @(posedge mclk);
    sys_rst <= 1'b0;
    // Software view: reset values, field widths, unmapped place
    apb(1'b0, `BBE_OFS_STATE, 32'h0000_0000);
    check("state", rdata, 32'h0000_0000);
    apb(1'b1, `BBE_OFS_FLAGS, 32'hffff_ffff);
    apb(1'b0, `BBE_OFS_FLAGS, 32'h0000_0000);
    check("flags rd", rdata, 32'h0000_00ff);
    apb(1'b1, `BBE_OFS_PC, 32'hffff_ffff);
    apb(1'b0, `BBE_OFS_PC, 32'h0000_0000);
    check("pc rd", rdata, 32'h0000_ffff);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    check("unmapped err", 32'(rerr), 32'h0000_0001);
    check("unmapped data", rdata, 32'h0000_0000);
    // Every branch code against both flag polarities, both offset signs
    for (int i = 1; i <= 18; i++) begin
      for (int j = 0; j < 4; j++) begin
        f = pat[j];
        off = j[0] ? 7'h40 : 7'h3f;
        prep(f, 16'h1000);
        exec(i[4:0], off, 3'h0, 8'h00, 5'h00);
        tk = brTaken(i[4:0], f);
        ex = tk ? 16'h1001 + {{9{off[6]}}, off} : 16'h1001;
        check("branch pc", 32'(pc_reg), 32'(ex));
        check("branch flags", 32'(flags_reg), 32'(f));
        check("branch ready", 32'(ready_reg), 32'(!tk));
        @(posedge mclk);
        #1;
        check("branch ready2", 32'(ready_reg), 32'h0000_0001);
      end
    end
    // Shifts, rotates and swap over edge data, carry in both ways
    for (int i = 'h15; i <= 'h1a; i++) begin
      for (int j = 0; j < 10; j++) begin
        d = dat[j % 5];
        f = (j < 5) ? 8'h70 : 8'hb1;
        prep(f, 16'h2000);
        exec(i[4:0], 7'h00, 3'h0, d, 5'h0b);
        ex = shiftExp(i[4:0], d, f);
        check("shift wr", 32'(regWrEn_reg), 32'h0000_0001);
        check("shift addr", 32'(regWrAddr_reg), 32'h0000_000b);
        check("shift data", 32'(regWrData_reg), 32'(ex[7:0]));
        check("shift flags", 32'(flags_reg), 32'(ex[15:8]));
        check("shift pc", 32'(pc_reg), 32'h0000_2001);
        @(posedge mclk);
        #1;
        check("shift wr2", 32'(regWrEn_reg), 32'h0000_0000);
      end
    end
    // Bit moves, flag set and clear, I/O bit set and clear per index
    for (int b = 0; b < 8; b++) begin
      d = 8'ha5;
      prep({1'b1, ~d[b], 6'h3f}, 16'h3000);
      exec(5'h1b, 7'h00, b[2:0], d, 5'h03);
      check("store", 32'(flags_reg), 32'({1'b1, d[b], 6'h3f}));
      prep({1'b0, b[0], 6'h00}, 16'h3000);
      d = 8'h5a;
      exec(5'h1c, 7'h00, b[2:0], d, 5'h04);
      d[b] = b[0];
      check("load", 32'(regWrData_reg), 32'(d));
      check("load flags", 32'(flags_reg), 32'({1'b0, b[0], 6'h00}));
      prep(8'h00, 16'h3000);
      exec(5'h1d, 7'h00, b[2:0], 8'h00, 5'h00);
      check("fset", 32'(flags_reg), 32'(8'h01 << b));
      prep(8'hff, 16'h3000);
      exec(5'h1e, 7'h00, b[2:0], 8'h00, 5'h00);
      check("fclr", 32'(flags_reg), 32'(8'hff ^ (8'h01 << b)));
      for (int s = 0; s < 2; s++) begin
        a = 5'h10 + 5'(b);
        ioMem[a] = s[0] ? 8'hff : 8'h00;
        prep(8'h5a, 16'h3000);
        exec(s[0] ? 5'h14 : 5'h13, 7'h00, b[2:0], 8'h00, a);
        check("io busy", 32'(ready_reg), 32'h0000_0000);
        @(posedge mclk);
        #1;
        check("io wr", 32'(ioWrEn_reg), 32'h0000_0001);
        waitReady();
        @(posedge mclk);
        #1;
        ex = s[0] ? 16'(~(8'h01 << b)) : 16'(8'h01 << b);
        check("io data", 32'(ioMem[a]), 32'(ex[7:0]));
        check("io flags", 32'(flags_reg), 32'h0000_005a);
      end
    end
    finishTest();
  end
endmodule : bbe_branch_bit_exec_tb_top
